// file: hdl/grb_meas_timer.sv
// publish timer: first result after power-on or restart, then periodic
`timescale 1ns/10ps
module grb_meas_timer
  import grb_pkg::*;
#(
  parameter int FIRST_CYCLES = FIRST_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // bank side
  grb_timer_if.timer tmr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cnt;
    logic publish;
  } grb_tmr_t;

  grb_tmr_t r;
  grb_tmr_t next_r;

  if (FIRST_CYCLES < 1 || PERIOD_CYCLES < 1) begin : g_chk
    $error("timer counts must be at least one cycle");
  end

  // sleep halts the count; a restart behaves like power-on
  always_comb begin
    next_r = r;
    next_r.publish = 1'b0;
    if (tmr.restart) begin
      next_r.cnt = 32'(FIRST_CYCLES - 1);
    end else if (!tmr.halt) begin
      if (r.cnt == 32'h0) begin
        next_r.publish = 1'b1;
        next_r.cnt = 32'(PERIOD_CYCLES - 1);
      end else begin
        next_r.cnt = r.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r.cnt <= 32'(FIRST_CYCLES - 1);
      r.publish <= 1'b0;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  assign tmr.publish = r.publish;
endmodule : grb_meas_timer

// file: hdl/grb_pkg.sv
// constants shared by the gauge register bank and its measurement timer
package grb_pkg;
  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR = 7'h36;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_VOLT = 8'h02;
  localparam logic [7:0] OFS_CHARGE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h06;
  localparam logic [7:0] OFS_ID = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0A;
  localparam logic [7:0] OFS_RATE = 8'h0B;
  localparam logic [7:0] OFS_SETTINGS = 8'h0C;
  localparam logic [7:0] OFS_REST = 8'h0E;
  localparam logic [7:0] OFS_FACTORY = 8'hFE;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESENSE = 16'h4000;
  localparam logic [15:0] CMD_FACTORY_INIT = 16'h5400;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_CHANGE = 5;
  localparam int FLG_LOW = 4;
  localparam int FLG_RESET = 0;
  localparam int CFG_SLEEP = 7;
  localparam int CFG_CHG_EN = 6;
  localparam int CFG_ALERT = 5;
  localparam int THR_W = 5;
  localparam logic [7:0] FLAGS_RST = 8'h01;
  localparam logic [15:0] SETTINGS_RST = 16'h321C;
  localparam logic [7:0] THR_BASE = 8'h20;
  localparam logic [15:0] ONE_PERCENT = 16'h0100;
  // arbitrary value, not tied to any real part
  localparam logic [15:0] PROD_ID_DEF = 16'h0A5A;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int FIRST_MS = 250;
  localparam int PERIOD_MS = 1000;
  localparam int FIRST_CYC = FIRST_MS * CLK_KHZ;
  localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;
endpackage : grb_pkg

// file: hdl/grb_register_bank.sv
// gauge register bank behind a serial two-wire slave port
//
// How it works
// - a write lands only when both bytes of the word arrived
// - unlisted addresses read zero and ignore writes
// - voltage word: 12-bit reading in bits 15:4, low nibble zero
// - first result 250 ms after power-on, then every second
// - charge word: whole percent high byte, 1/256 percent low byte
// - 4000h to the command word restarts sensing like power-on
// - 5400h to the factory word resets every register and restarts sensing; the serial port state and pointer are kept
// - id word returns a fixed production value
// - charge-rate byte is read-only, percent per hour
// - tuning byte at 0Ch is read/write, resets to 32h
// - settings bit 7 puts the gauge to sleep, resets to 0
// - settings bit 6 enables the one-percent change flag
// - settings bit 5 is sticky alert, cleared by writing 0
// - bits 4:0 low threshold, 00000 is 32 percent, reset 1Ch
// - a change or low flag setting also sets the alert bit; the reset indicator does not
// - change flag sets on a one-percent move, sticky until cleared
// - low flag sets below threshold, sticky until cleared
// - reset indicator sets at reset, status resets to 01h
// - status: change bit 5, low bit 4, reset indicator bit 0
// - alert pin held low while an alert is pending
// - rising edge on the resense pin restarts sensing
// - slave address 36h, first byte pointer, then data
`timescale 1ns/10ps
module grb_register_bank
  import grb_pkg::*;
#(
  parameter int FIRST_CYCLES = FIRST_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC,
  parameter logic [15:0] PROD_ID = PROD_ID_DEF
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // two-wire port
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // pins
  input wire logic i_resense_pin,
  output logic o_alert_n,
  // gauge core
  input wire logic [11:0] i_meas_voltage,
  input wire logic [15:0] i_meas_charge,
  input wire logic [7:0] i_meas_rate,
  input wire logic [15:0] i_meas_rest,
  output logic o_restart,
  output logic o_sleep,
  output logic [7:0] o_gauge_tuning
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_WAIT
  } grb_st_t;

  typedef struct packed {
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] pin_q;
    grb_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack_on;
    logic rd_acked;
    logic [7:0] ptr;
    logic [7:0] wr_hi;
    logic [7:0] hi_addr;
    logic hi_ok;
    logic [11:0] voltage;
    logic [15:0] charge;
    logic [7:0] rate;
    logic [15:0] rest;
    logic [15:0] ref_charge;
    logic ref_ok;
    logic change_flag;
    logic low_flag;
    logic reset_indicator;
    logic [7:0] gauge_tuning;
    logic sleep;
    logic change_irq_enable;
    logic alert;
    logic [THR_W-1:0] low_charge_threshold;
    logic restart;
    logic sda_out;
    logic sda_oe;
    logic alert_n;
  } grb_bank_t;

  grb_bank_t r;
  grb_bank_t next_r;
  grb_timer_if tmr ();

  grb_meas_timer #(
    .FIRST_CYCLES(FIRST_CYCLES),
    .PERIOD_CYCLES(PERIOD_CYCLES)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .tmr(tmr.timer)
  );

  assign tmr.restart = r.restart;
  assign tmr.halt = r.sleep;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction : abs_diff

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    unique case (a)
      OFS_VOLT: read_byte = r.voltage[11:4];
      OFS_VOLT + 8'h01: read_byte = {r.voltage[3:0], 4'h0};
      OFS_CHARGE: read_byte = r.charge[15:8];
      OFS_CHARGE + 8'h01: read_byte = r.charge[7:0];
      OFS_ID: read_byte = PROD_ID[15:8];
      OFS_ID + 8'h01: read_byte = PROD_ID[7:0];
      OFS_FLAGS: read_byte = {2'h0, r.change_flag, r.low_flag, 3'h0, r.reset_indicator};
      OFS_RATE: read_byte = r.rate;
      OFS_SETTINGS: read_byte = r.gauge_tuning;
      OFS_SETTINGS + 8'h01: read_byte = {r.sleep, r.change_irq_enable, r.alert,
                                         r.low_charge_threshold};
      OFS_REST: read_byte = r.rest[15:8];
      OFS_REST + 8'h01: read_byte = r.rest[7:0];
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // ----------------------------------------------------------------
  // bus edges and word commit
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] wr_byte;
  logic byte_done;
  logic commit;
  logic [15:0] wr_word;
  logic [7:0] wr_base;
  logic hit_resense;
  logic hit_factory;
  logic hit_flags;
  logic hit_settings;
  logic pin_rise;
  logic change_ev;
  logic low_ev;
  logic [7:0] low_level;
  logic [7:0] rd_byte;

  // only the second and third stages are looked at; the first is metastability guard
  assign scl_rise = r.scl_q[1] & ~r.scl_q[2];
  assign scl_fall = ~r.scl_q[1] & r.scl_q[2];
  assign bus_start = r.scl_q[1] & r.scl_q[2] & r.sda_q[2] & ~r.sda_q[1];
  assign bus_stop = r.scl_q[1] & r.scl_q[2] & ~r.sda_q[2] & r.sda_q[1];
  assign pin_rise = r.pin_q[1] & ~r.pin_q[2];
  assign wr_byte = {r.sh[6:0], r.sda_q[1]};
  assign byte_done = (r.st == ST_WDATA) && scl_rise && (r.cnt == 4'h7);
  // high byte must be held for the matching even address, else nothing lands
  assign commit = byte_done && r.ptr[0] && r.hi_ok && (r.hi_addr[7:1] == r.ptr[7:1]);
  assign wr_word = {r.wr_hi, wr_byte};
  assign wr_base = {r.ptr[7:1], 1'b0};
  assign hit_resense = commit && (wr_base == OFS_CMD) && (wr_word == CMD_RESENSE);
  assign hit_factory = commit && (wr_base == OFS_FACTORY) && (wr_word == CMD_FACTORY_INIT);
  // only these two words take data; every read-only word has no write path
  assign hit_flags = commit && (wr_base == OFS_FLAGS);
  assign hit_settings = commit && (wr_base == OFS_SETTINGS);
  // threshold 00000 stands for 32 percent, 11111 for 1 percent
  assign low_level = THR_BASE - {3'h0, r.low_charge_threshold};
  assign change_ev = tmr.publish && r.change_irq_enable && r.ref_ok &&
                     (abs_diff(i_meas_charge, r.ref_charge) >= ONE_PERCENT);
  assign low_ev = tmr.publish && (i_meas_charge[15:8] < low_level);
  assign rd_byte = read_byte(r.ptr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.scl_q = {r.scl_q[1:0], i_scl};
    next_r.sda_q = {r.sda_q[1:0], i_sda_in};
    next_r.pin_q = {r.pin_q[1:0], i_resense_pin};
    next_r.restart = hit_resense || pin_rise;

    // serial slave
    if (bus_start) begin
      next_r.st = ST_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.ack_on = 1'b0;
      next_r.hi_ok = 1'b0;
    end else if (bus_stop) begin
      next_r.st = ST_IDLE;
      next_r.sda_oe = 1'b0;
      next_r.hi_ok = 1'b0;
    end else begin
      unique case (r.st)
        ST_IDLE, ST_WAIT: begin
          next_r.sda_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            next_r.sh = wr_byte;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7) begin
              next_r.cnt = 4'h0;
              unique case (r.st)
                ST_ADDR: begin
                  next_r.st = (r.sh[6:0] == I2C_ADDR) ? ST_ADDR_ACK : ST_WAIT;
                  next_r.rd_acked = r.sda_q[1];
                end
                ST_PTR: begin
                  next_r.ptr = wr_byte;
                  next_r.hi_ok = 1'b0;
                  next_r.st = ST_PTR_ACK;
                end
                default: begin
                  if (!r.ptr[0]) begin
                    next_r.wr_hi = wr_byte;
                    next_r.hi_addr = r.ptr;
                    next_r.hi_ok = 1'b1;
                  end else begin
                    next_r.hi_ok = 1'b0;
                  end
                  next_r.ptr = r.ptr + 8'h01;
                  next_r.st = ST_WDATA_ACK;
                end
              endcase
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (!r.ack_on) begin
              next_r.ack_on = 1'b1;
              next_r.sda_oe = 1'b1;
            end else begin
              next_r.ack_on = 1'b0;
              next_r.sda_oe = 1'b0;
              if (r.st == ST_ADDR_ACK && r.rd_acked) begin
                next_r.sh = rd_byte;
                next_r.sda_oe = ~rd_byte[7];
                next_r.st = ST_RDATA;
              end else begin
                next_r.st = (r.st == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt == 4'h8) begin
              next_r.cnt = 4'h0;
              next_r.sda_oe = 1'b0;
              next_r.ptr = r.ptr + 8'h01;
              next_r.st = ST_RDATA_ACK;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.sda_oe = ~r.sh[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            next_r.ack_on = ~r.sda_q[1];
          end else if (scl_fall) begin
            next_r.ack_on = 1'b0;
            if (r.ack_on) begin
              next_r.sh = rd_byte;
              next_r.sda_oe = ~rd_byte[7];
              next_r.st = ST_RDATA;
            end else begin
              next_r.st = ST_WAIT;
            end
          end
        end
      endcase
    end

    // register writes; host clears flags by writing 0, a same-cycle set still wins
    if (hit_flags) begin
      next_r.change_flag = r.change_flag & wr_word[8 + FLG_CHANGE];
      next_r.low_flag = r.low_flag & wr_word[8 + FLG_LOW];
      next_r.reset_indicator = r.reset_indicator & wr_word[8 + FLG_RESET];
    end
    if (hit_settings) begin
      next_r.gauge_tuning = wr_word[15:8];
      next_r.sleep = wr_word[CFG_SLEEP];
      next_r.change_irq_enable = wr_word[CFG_CHG_EN];
      next_r.alert = r.alert & wr_word[CFG_ALERT];
      next_r.low_charge_threshold = wr_word[THR_W-1:0];
    end

    // measurement publish
    if (tmr.publish) begin
      next_r.voltage = i_meas_voltage;
      next_r.charge = i_meas_charge;
      next_r.rate = i_meas_rate;
      next_r.rest = i_meas_rest;
      if (change_ev || !r.ref_ok || !r.change_irq_enable) begin
        next_r.ref_charge = i_meas_charge;
      end
      next_r.ref_ok = 1'b1;
    end
    if (next_r.restart) begin
      next_r.ref_ok = 1'b0;
    end
    if (change_ev) begin
      next_r.change_flag = 1'b1;
    end
    if (low_ev) begin
      next_r.low_flag = 1'b1;
    end
    if (change_ev || low_ev) begin
      next_r.alert = 1'b1;
    end

    // factory init behaves like power-on for every register
    if (hit_factory) begin
      next_r.change_flag = 1'b0;
      next_r.low_flag = 1'b0;
      next_r.reset_indicator = FLAGS_RST[FLG_RESET];
      next_r.gauge_tuning = SETTINGS_RST[15:8];
      next_r.sleep = SETTINGS_RST[CFG_SLEEP];
      next_r.change_irq_enable = SETTINGS_RST[CFG_CHG_EN];
      next_r.alert = SETTINGS_RST[CFG_ALERT];
      next_r.low_charge_threshold = SETTINGS_RST[THR_W-1:0];
      next_r.voltage = 12'h000;
      next_r.charge = 16'h0000;
      next_r.rate = 8'h00;
      next_r.rest = 16'h0000;
      next_r.ref_ok = 1'b0;
      next_r.restart = 1'b1;
    end
    // sleep does not end an alert; only clearing does
    next_r.alert_n = ~(next_r.alert & (next_r.change_flag | next_r.low_flag));
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.scl_q <= 3'h7;
      r.sda_q <= 3'h7;
      r.st <= ST_IDLE;
      r.reset_indicator <= FLAGS_RST[FLG_RESET];
      r.gauge_tuning <= SETTINGS_RST[15:8];
      r.sleep <= SETTINGS_RST[CFG_SLEEP];
      r.change_irq_enable <= SETTINGS_RST[CFG_CHG_EN];
      r.alert <= SETTINGS_RST[CFG_ALERT];
      r.low_charge_threshold <= SETTINGS_RST[THR_W-1:0];
      r.alert_n <= 1'b1;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_sda_out = r.sda_out;
  assign o_sda_oe = r.sda_oe;
  assign o_alert_n = r.alert_n;
  assign o_restart = r.restart;
  assign o_sleep = r.sleep;
  assign o_gauge_tuning = r.gauge_tuning;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_publish_voltage;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (tmr.publish && i_clk_en && !hit_factory) |=> (r.voltage == $past(i_meas_voltage));
  endproperty
  a_publish_voltage: assert property (p_publish_voltage) else $error("voltage not published");

  property p_resense_restart;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (hit_resense && i_clk_en) |=> (o_restart && tmr.restart) ##1 (u_timer.r.cnt != 32'h0);
  endproperty
  a_resense_restart: assert property (p_resense_restart) else $error("no restart");

  property p_factory_init;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (hit_factory && i_clk_en) |=> (o_gauge_tuning == SETTINGS_RST[15:8]) &&
      r.reset_indicator && !o_sleep && o_restart;
  endproperty
  a_factory_init: assert property (p_factory_init) else $error("factory init failed");

  property p_sleep_write;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (hit_settings && !hit_factory && i_clk_en) |=> (o_sleep == $past(wr_word[CFG_SLEEP]));
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("sleep bit not written");

  property p_tuning_hold;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    !(hit_settings || hit_factory) |=> $stable(o_gauge_tuning);
  endproperty
  a_tuning_hold: assert property (p_tuning_hold) else $error("tuning changed by stray write");

  property p_change_sets;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (change_ev && i_clk_en && !hit_factory) |=> (r.change_flag && r.alert);
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change event lost");

  property p_low_sets;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (low_ev && i_clk_en && !hit_factory) |=> (r.low_flag && r.alert && !o_alert_n);
  endproperty
  a_low_sets: assert property (p_low_sets) else $error("low event lost");

  property p_alert_pin;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    o_alert_n == !(r.alert && (r.change_flag || r.low_flag));
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin mismatch");

  property p_addr_ack;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (r.st == ST_ADDR && scl_rise && r.cnt == 4'h7 && r.sh[6:0] != I2C_ADDR && !bus_start &&
      !bus_stop && i_clk_en) |=> (r.st == ST_WAIT) [*2];
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("foreign address answered");

  c_resense: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) hit_resense);
  c_factory: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) hit_factory);
  c_alert: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) $fell(o_alert_n));
  c_read: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) r.st == ST_RDATA_ACK);
endmodule : grb_register_bank

// file: hdl/grb_timer_if.sv
// carrier between the register bank and its measurement timer
`timescale 1ns/10ps
interface grb_timer_if;
  logic restart;
  logic halt;
  logic publish;
  modport bank (output restart, output halt, input publish);
  modport timer (input restart, input halt, output publish);
endinterface : grb_timer_if

// file: sim/grb_i2c_host.sv
// two-wire host model: drives the bus clock and pulls the data line
`timescale 1ns/10ps
module grb_i2c_host (
  // clock
  input wire logic i_sys_clk,
  // bus
  input wire logic i_dev_pull,
  output logic o_scl,
  output logic o_sda
);
  logic pull;
  // open drain with pull-up, so a released line reads high
  assign o_sda = ~(pull | i_dev_pull);
  initial pull = 1'b0;
  initial o_scl = 1'b1;
  // ten cycles per half period keeps margin over the synchronisers
  task automatic hp();
    repeat (10) @(negedge i_sys_clk);
  endtask : hp
  // serves as repeated start too: data released before the clock rises
  task automatic start();
    pull = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    pull = 1'b1;
    hp();
    o_scl = 1'b0;
    hp();
  endtask : start
  task automatic stop();
    pull = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    pull = 1'b0;
    hp();
  endtask : stop
  // eight bits msb first, then a ninth bit; m is what the host offers there
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
                      output logic k);
    logic [8:0] s;
    s = {d, m};
    for (int i = 8; i >= 0; i--) begin
      pull = ~s[i];
      hp();
      o_scl = 1'b1;
      hp();
      s[i] = o_sda;
      o_scl = 1'b0;
      hp();
    end
    q = s[8:1];
    k = s[0];
  endtask : xfer
endmodule : grb_i2c_host

// file: sim/tb_top.sv
// testbench: register bank reached through the two-wire host model
`timescale 1ns/10ps
module tb_top;
  import grb_pkg::*;
  logic clk, rstn, pin, scl, sda, oe, so, sleep, alert_n, rs, k;
  logic [11:0] vin;
  logic [15:0] cin, rin, r, x;
  logic [7:0] ratein, tune;
  int error_cnt, compares, nrs, seed, n;
  grb_register_bank #(.FIRST_CYCLES(20), .PERIOD_CYCLES(50)) dut (.i_sys_clk(clk),
    .i_resetn(rstn), .i_clk_en(1'b1), .i_scl(scl), .i_sda_in(sda), .o_sda_out(so),
    .o_sda_oe(oe), .i_resense_pin(pin), .o_alert_n(alert_n), .i_meas_voltage(vin),
    .i_meas_charge(cin), .i_meas_rate(ratein), .i_meas_rest(rin), .o_restart(rs),
    .o_sleep(sleep), .o_gauge_tuning(tune));
  // the device pulls low only while it enables its driver with a low data value
  grb_i2c_host host (.i_sys_clk(clk), .i_dev_pull(oe & ~so), .o_scl(scl), .o_sda(sda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // counted mid-cycle, where the one-cycle pulse has settled
  always @(negedge clk) if (rs === 1'b1) nrs++;
  task automatic wt(input int c);
    repeat (c) @(negedge clk);
  endtask : wt
  // voltage word: reading in the upper twelve bits, low nibble zero
  function automatic logic [15:0] volt_word(input logic [11:0] v);
    volt_word = {v, 4'h0};
  endfunction : volt_word
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // n data bytes; a single byte leaves the word unfinished
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    logic [7:0] q;
    host.start();
    host.xfer({I2C_ADDR, 1'b0}, 1'b1, q, k);
    host.xfer(a, 1'b1, q, k);
    for (int i = 0; i < n; i++) host.xfer(d[15 - 8 * i -: 8], 1'b1, q, k);
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    host.start();
    host.xfer({I2C_ADDR, 1'b0}, 1'b1, d[7:0], k);
    host.xfer(a, 1'b1, d[7:0], k);
    host.start();
    host.xfer({I2C_ADDR, 1'b1}, 1'b1, d[7:0], k);
    host.xfer(8'hFF, 1'b0, d[15:8], k);
    host.xfer(8'hFF, 1'b1, d[7:0], k);
    host.stop();
  endtask : rd
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (99000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    seed = 32'h103C;
    {rstn, pin, vin, ratein, rin} = '0;
    cin = 16'h3200;
    wt(4);
    rstn = 1'b1;
    wt(4);
    rd(OFS_FLAGS, r);
    chk(r, {FLAGS_RST, 8'h00});
    rd(OFS_SETTINGS, r);
    chk(r, SETTINGS_RST);
    rd(OFS_ID, r);
    chk(r, PROD_ID_DEF);
    rd(OFS_VOLT, r);
    chk(r, volt_word(vin));
    for (int i = 0; i < 2; i++) begin
      vin = 12'($random(seed));
      cin = {8'h28, 8'($random(seed))};
      ratein = 8'($random(seed));
      rin = 16'($random(seed));
      wt(120);
      rd(OFS_VOLT, r);
      chk(r, volt_word(vin));
      rd(OFS_CHARGE, r);
      chk(r, cin);
      rd(OFS_FLAGS, r);
      chk(r, {FLAGS_RST, ratein});
      rd(OFS_REST, r);
      chk(r, rin);
    end
    wr(OFS_VOLT, 16'hFFFF, 2);
    wr(OFS_SETTINGS, 16'hAB00, 1);
    rd(OFS_VOLT, r);
    chk(r, volt_word(vin));
    rd(OFS_SETTINGS, r);
    chk(r, SETTINGS_RST);
    // writing 1 to the alert bit must not set it
    x = {8'($random(seed)), 8'hBE};
    wr(OFS_SETTINGS, x, 2);
    rd(OFS_SETTINGS, r);
    chk(r, {x[15:8], 8'h9E});
    chk({tune, 7'h0, sleep}, {x[15:8], 8'h01});
    // asleep: a new reading must not be published
    vin = ~vin;
    wt(120);
    rd(OFS_VOLT, r);
    chk(r, volt_word(~vin));
    cin = 16'h2000;
    wr(OFS_SETTINGS, {x[15:8], 8'h00}, 2);
    wt(120);
    rd(OFS_FLAGS, r);
    chk(r[15:8], FLAGS_RST);
    cin = 16'h1FFF;
    wt(120);
    chk(alert_n, 1'b0);
    rd(OFS_FLAGS, r);
    chk(r[15:8], 8'h11);
    rd(OFS_SETTINGS, r);
    chk(r, {x[15:8], 8'h20});
    cin = 16'h3000;
    wr(OFS_FLAGS, 16'h0000, 2);
    wr(OFS_SETTINGS, {x[15:8], 8'h40}, 2);
    wt(120);
    chk(alert_n, 1'b1);
    cin = 16'h30FF;
    wt(120);
    rd(OFS_FLAGS, r);
    chk(r[15:8], 8'h00);
    cin = 16'h3100;
    wt(120);
    rd(OFS_FLAGS, r);
    chk(r[15:8], 8'h20);
    n = nrs;
    wr(OFS_CMD, CMD_RESENSE, 2);
    chk(16'(nrs - n), 16'h0001);
    pin = 1'b1;
    wt(10);
    pin = 1'b0;
    chk(16'(nrs - n), 16'h0002);
    wr(OFS_FACTORY, CMD_FACTORY_INIT, 2);
    rd(OFS_SETTINGS, r);
    chk(r, SETTINGS_RST);
    rd(OFS_FLAGS, r);
    chk(r[15:8], FLAGS_RST);
    host.start();
    host.xfer(8'h70, 1'b1, x[7:0], k);
    chk(k, 1'b1);
    host.start();
    host.xfer({I2C_ADDR, 1'b0}, 1'b1, x[7:0], k);
    chk(k, 1'b0);
    host.stop();
    complete_run();
  end
endmodule : tb_top
